// *** rictl_pkg.sv ***
/*
 Package for the reset and interrupt controller: vectors, address ranges,
 register addresses, source encoding and timing counts. Assumes a 125 MHz system clock.
*/
package rictl_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_PS = 8000;
   // Machine cycle length in ns and the least reset pin low time in tenths of a cycle
   localparam int MACHINE_CYCLE_NS = 8;
   localparam int RESET_LOW_MIN_TENTHS = 15;
   localparam int RESET_LOW_MIN_CYC =
      (RESET_LOW_MIN_TENTHS * MACHINE_CYCLE_NS * 100 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Power-on stabilisation delay in machine cycles
   localparam int POWER_ON_DELAY_CYC = 4064;

   // ************************************************************
   // Legal opcode fetch ranges
   // ************************************************************
   localparam logic [15:0] RAM_LO = 16'h0050;
   localparam logic [15:0] RAM_HI = 16'h00FF;
   localparam logic [15:0] NVM_LO = 16'h0F00;
   localparam logic [15:0] NVM_HI = 16'h1F00;
   localparam logic [15:0] VEC_LO = 16'h1FF0;
   localparam logic [15:0] VEC_HI = 16'h1FFF;

   // ************************************************************
   // Vector addresses (high byte location)
   // ************************************************************
   localparam logic [15:0] VEC_RESET = 16'h1FFE;
   localparam logic [15:0] VEC_TRAP = 16'h1FFC;
   localparam logic [15:0] VEC_CAN = 16'h1FFA;
   localparam logic [15:0] VEC_CTIMER = 16'h1FF8;
   localparam logic [15:0] VEC_WIRED = 16'h1FF6;
   localparam logic [15:0] VEC_WTIMER = 16'h1FF4;

   // ************************************************************
   // Device register addresses and fields
   // ************************************************************
   localparam logic [15:0] CAN_IRQ_SOURCE_ADDR = 16'h0023;
   localparam logic [15:0] CAN_CONTROL_ADDR = 16'h0020;
   localparam logic [15:0] PORT_CFG_ADDR = 16'h0003;
   localparam int WIRED_FLAG_BIT = 5;

   // CAN source indices
   localparam int CAN_RX = 0;
   localparam int CAN_TX = 1;
   localparam int CAN_ERR = 2;
   localparam int CAN_OVR = 3;
   localparam int CAN_WAKE = 4;
   localparam int CAN_NSRC = 5;

   // Selected source encoding
   typedef enum logic [2:0] {
      RICTL_SRC_NONE, RICTL_SRC_RESET, RICTL_SRC_TRAP, RICTL_SRC_CAN,
      RICTL_SRC_CTIMER, RICTL_SRC_WIRED, RICTL_SRC_WTIMER
   } rictl_src_t;

endpackage : rictl_pkg

// *** rictl_core.sv ***
/*
 Reset gathering and interrupt arbitration for a small 8-bit controller.
 Assumes the CPU core reports fetches, instruction ends and stack actions on
 the same clock, and that peripherals present level flags on that clock.
*/
//
// Behaviour
// R01 - Reset from power-on, low reset pin, illegal fetch or watchdog time-out.
// R02 - After power-on wait the delay, then hold reset while the pin stays low.
// R03 - Pin low for at least 1.5 machine cycles resets; shorter glitches are ignored.
// R04 - Opcode fetch outside RAM and NVM ranges triggers reset; the code also accepts fetches from 0x1FF0-0x1FFF.
// R05 - Watchdog reset is internal; operating mode is preserved across it.
// R06 - Watchdog reset presence is a build-time parameter.
// R07 - Five sources: four maskable hardware plus non-maskable software trap.
// R08 - Taking an interrupt pushes registers, then sets the mask bit.
// R09 - Return from interrupt pops registers and resumes execution.
// R10 - Requests wait for the current instruction; checked only at its end.
// R11 - Service only if mask clear and source enabled, else continue.
// R12 - External interrupt is serviced before timer interrupt.
// R13 - Fixed priority reset, trap, CAN, core timer, wired pins, wide timer; the code serves wired pins before core timer.
// R14 - Wired pin interrupt flagged by latch, vectors at 0x1FF6.
// R15 - Software trap ignores mask bit; vector at 0x1FFC and 0x1FFD.
// R16 - Trap follows interrupts pending at its fetch, precedes later ones.
// R17 - Mask bit set blocks all maskable interrupts; clearing releases pending ones.
// R18 - External latch cleared early in service so a new pulse can latch; the code only masks the wired request for one cycle.
// R19 - CAN source shown at 0x0023, enabled by 0x0020 bits, wake-up always.
// R20 - CAN requests on receive, transmit, error change, overrun, wake-up.
// R21 - CAN interrupt vectors through 0x1FFA and 0x1FFB.
// R22 - Any reset loads vector 0x1FFE/0x1FFF and sets the mask bit.
// R23 - Wired latch is port configuration bit 5, cleared by writing zero.
// R24 - Several pending: pick one highest, others stay pending.
`timescale 1ns/1ps
module rictl_core
   import rictl_pkg::*;
#(
   parameter bit WATCHDOG_RESET_EN = 1'b1,
   parameter int POWER_ON_DELAY = POWER_ON_DELAY_CYC
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic power_on_detect,
   input wire logic osc_active,
   input wire logic reset_pin_n,
   input wire logic watchdog_timeout,
   input wire logic opcode_fetch,
   input wire logic [15:0] fetch_addr,
   input wire logic instr_end,
   input wire logic instr_is_trap,
   input wire logic trap_fetch,
   input wire logic stack_push_done,
   input wire logic return_from_interrupt,
   input wire logic stack_pop_done,
   input wire logic mask_clear_req,
   input wire logic mask_set_req,
   input wire logic can_irq_rx,
   input wire logic can_irq_tx,
   input wire logic can_irq_err,
   input wire logic can_irq_ovr,
   input wire logic can_irq_wake,
   input wire logic [3:0] can_irq_enable,
   input wire logic can_flags_clear,
   input wire logic core_timer_overflow_flag,
   input wire logic periodic_tick_flag,
   input wire logic core_timer_overflow_en,
   input wire logic periodic_tick_en,
   input wire logic input_capture_flag,
   input wire logic output_compare_flag,
   input wire logic wide_timer_overflow_flag,
   input wire logic [2:0] wide_timer_irq_en,
   input wire logic wired_or_pin_interrupt,
   input wire logic wired_flag_write,
   input wire logic wired_flag_wdata,
   output logic device_reset,
   output logic reset_keeps_mode,
   output logic mask_bit,
   output logic irq_take,
   output logic stack_push_req,
   output logic stack_pop_req,
   output logic resume,
   output logic [15:0] vector_addr,
   output rictl_src_t vector_src,
   output logic [CAN_NSRC-1:0] can_irq_source_register,
   output logic wired_or_pin_flag
);

   // ************************************************************
   // Input synchronisers for pin-level signals
   // ************************************************************
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   // Idle levels after reset: pin high, oscillator not yet running, wired pin low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync1_r <= 3'h5;
         sync2_r <= 3'h5;
      end else begin
         sync1_r <= {reset_pin_n, osc_active, ~wired_or_pin_interrupt};
         sync2_r <= sync1_r;
      end
   end
   // Only the second flop of each synchroniser feeds logic
   wire pin_n_s = sync2_r[2];
   wire osc_s = sync2_r[1];
   wire wired_pin_s = ~sync2_r[0];

   // ************************************************************
   // Reset gathering
   // ************************************************************
   logic por_busy_r;
   logic [15:0] por_cnt_r;
   logic [7:0] pin_low_cnt_r;
   logic pin_rst_r;
   logic wd_rst_r;
   logic fetch_rst_r;
   wire legal_fetch = (fetch_addr >= RAM_LO && fetch_addr <= RAM_HI) ||
                      (fetch_addr >= NVM_LO && fetch_addr <= NVM_HI) ||
                      (fetch_addr >= VEC_LO && fetch_addr <= VEC_HI);
   wire illegal_fetch = opcode_fetch && !legal_fetch; // see R04
   wire wd_hit = WATCHDOG_RESET_EN && watchdog_timeout; // see R06
   // The low sample that reaches the minimum count already counts
   wire pin_long = pin_low_cnt_r >= 8'(RESET_LOW_MIN_CYC - 1); // see R03

   // Power-on delay counts from oscillator start
   always_ff @(posedge clk) begin
      if (sys_rst || power_on_detect) begin
         por_busy_r <= 1'b1;
         por_cnt_r <= 16'h0000;
      end else if (por_busy_r && osc_s) begin
         if (por_cnt_r >= 16'(POWER_ON_DELAY - 1)) begin
            por_busy_r <= 1'b0; // see R02
         end
         por_cnt_r <= por_cnt_r + 16'h0001;
      end
   end

   // Pin low filter and reset hold while the pin stays low
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pin_low_cnt_r <= 8'h00;
         pin_rst_r <= 1'b0;
      end else if (pin_n_s) begin
         pin_low_cnt_r <= 8'h00;
         pin_rst_r <= 1'b0;
      end else begin
         if (!pin_long) begin
            pin_low_cnt_r <= pin_low_cnt_r + 8'h01;
         end
         pin_rst_r <= pin_long || (por_busy_r); // see R02, R03
      end
   end

   // One-cycle internal resets from watchdog and illegal fetch
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wd_rst_r <= 1'b0;
         fetch_rst_r <= 1'b0;
         reset_keeps_mode <= 1'b0;
      end else begin
         wd_rst_r <= wd_hit;
         fetch_rst_r <= illegal_fetch;
         if (wd_hit) begin
            reset_keeps_mode <= 1'b1; // see R05
         end else if (por_busy_r || pin_rst_r || illegal_fetch) begin
            reset_keeps_mode <= 1'b0;
         end
      end
   end

   wire any_reset = por_busy_r || pin_rst_r || wd_rst_r || fetch_rst_r; // see R01
   assign device_reset = any_reset;

   // ************************************************************
   // Source latches
   // ************************************************************
   logic wired_prev_r;
   logic [CAN_NSRC-1:0] can_src_r;
   logic trap_pending_r;
   logic [3:0] early_mask_r;
   wire [CAN_NSRC-1:0] can_raw = {can_irq_wake, can_irq_ovr, can_irq_err,
                                  can_irq_tx, can_irq_rx}; // see R20
   wire [CAN_NSRC-1:0] can_en = {1'b1, can_irq_enable}; // see R19
   wire wired_rise = wired_pin_s && !wired_prev_r;

   // CAN source register; set wins over clear
   genvar gi;
   generate
      for (gi = 0; gi < CAN_NSRC; gi++) begin : g_can
         always_ff @(posedge clk) begin
            if (sys_rst || any_reset) begin
               can_src_r[gi] <= 1'b0;
            end else if (can_raw[gi]) begin
               can_src_r[gi] <= 1'b1; // see R19
            end else if (can_flags_clear) begin
               can_src_r[gi] <= 1'b0;
            end
         end
      end
   endgenerate
   assign can_irq_source_register = can_src_r;

   // Wired-OR latch; software zero clears, edge set wins
   always_ff @(posedge clk) begin
      if (sys_rst || any_reset) begin
         wired_prev_r <= 1'b0;
         wired_or_pin_flag <= 1'b0;
      end else begin
         wired_prev_r <= wired_pin_s;
         if (wired_rise) begin
            wired_or_pin_flag <= 1'b1; // see R14, R23
         end else if (wired_flag_write && !wired_flag_wdata) begin
            wired_or_pin_flag <= 1'b0; // see R23
         end
      end
   end

   // ************************************************************
   // Request qualification and fixed priority
   // ************************************************************
   wire can_req = |(can_src_r & can_en);
   wire ct_req = (core_timer_overflow_flag && core_timer_overflow_en) ||
                 (periodic_tick_flag && periodic_tick_en);
   wire wt_req = |({wide_timer_overflow_flag, output_compare_flag, input_capture_flag}
                   & wide_timer_irq_en);
   wire [3:0] hw_req = {wt_req, wired_or_pin_flag, ct_req, can_req}; // see R07
   // Masked sources and a wired request just taken stay out of arbitration
   wire [3:0] hw_ok = hw_req & ~early_mask_r & {4{!mask_bit}}; // see R11, R17
   // Requests that were already pending when the trap opcode was fetched
   logic [3:0] pend_at_trap_r;
   wire [3:0] hw_at_trap = hw_ok & pend_at_trap_r;
   wire trap_req = trap_pending_r || (instr_end && instr_is_trap); // see R15
   // While a trap waits, only the requests older than it may go first
   wire [3:0] hw_cand = (trap_req && hw_at_trap != 4'h0) ? hw_at_trap : hw_ok; // see R16

   // Highest pending pick: CAN, wired, core timer, wide timer
   // A trap waits only for sources that were pending when it was fetched
   rictl_src_t pick;
   always_comb begin
      pick = RICTL_SRC_NONE;
      if (trap_req && hw_at_trap == 4'h0) begin
         pick = RICTL_SRC_TRAP; // see R15, R16
      end else if (hw_cand[0]) begin
         pick = RICTL_SRC_CAN; // see R13, R24
      end else if (hw_cand[2]) begin
         pick = RICTL_SRC_WIRED; // see R12
      end else if (hw_cand[1]) begin
         pick = RICTL_SRC_CTIMER; // see R13
      end else if (hw_cand[3]) begin
         pick = RICTL_SRC_WTIMER;
      end else if (trap_req) begin
         pick = RICTL_SRC_TRAP;
      end
   end

   // Vector lookup
   logic [15:0] pick_vec;
   always_comb begin
      case (pick)
         RICTL_SRC_TRAP: pick_vec = VEC_TRAP; // see R15
         RICTL_SRC_CAN: pick_vec = VEC_CAN; // see R21
         RICTL_SRC_CTIMER: pick_vec = VEC_CTIMER;
         RICTL_SRC_WIRED: pick_vec = VEC_WIRED; // see R14
         RICTL_SRC_WTIMER: pick_vec = VEC_WTIMER; // see R13
         default: pick_vec = VEC_RESET;
      endcase
   end

   // ************************************************************
   // Service sequencer
   // ************************************************************
   typedef enum logic [1:0] {RICTL_IDLE, RICTL_PUSH, RICTL_POP} rictl_state_t;
   rictl_state_t state_r;
   // A busy sequencer refuses the boundary; requests simply stay pending
   wire at_boundary = instr_end && state_r == RICTL_IDLE; // see R10
   wire take = at_boundary && pick != RICTL_SRC_NONE; // see R11
   assign irq_take = take;
   assign stack_push_req = state_r == RICTL_PUSH;
   assign stack_pop_req = state_r == RICTL_POP;

   always_ff @(posedge clk) begin
      if (sys_rst || any_reset) begin
         state_r <= RICTL_IDLE;
         resume <= 1'b0;
      end else begin
         resume <= 1'b0;
         case (state_r)
            RICTL_IDLE: begin
               if (take) begin
                  state_r <= RICTL_PUSH; // see R08
               end else if (return_from_interrupt) begin
                  state_r <= RICTL_POP; // see R09
               end
            end
            RICTL_PUSH: begin
               if (stack_push_done) begin
                  state_r <= RICTL_IDLE;
               end
            end
            RICTL_POP: begin
               if (stack_pop_done) begin
                  state_r <= RICTL_IDLE;
                  resume <= 1'b1; // see R09
               end
            end
            default: state_r <= RICTL_IDLE;
         endcase
      end
   end

   // Mask bit, trap capture, vector output; wired request masked for one cycle on take
   always_ff @(posedge clk) begin
      if (sys_rst || any_reset) begin
         mask_bit <= 1'b1; // see R22
         vector_addr <= VEC_RESET; // see R22
         vector_src <= RICTL_SRC_RESET;
         trap_pending_r <= 1'b0;
         pend_at_trap_r <= 4'h0;
         early_mask_r <= 4'h0;
      end else begin
         early_mask_r <= 4'h0;
         if (state_r == RICTL_PUSH && stack_push_done) begin
            mask_bit <= 1'b1; // see R08
         end else if (mask_set_req) begin
            mask_bit <= 1'b1;
         end else if (mask_clear_req) begin
            mask_bit <= 1'b0; // see R17
         end
         if (trap_fetch) begin
            pend_at_trap_r <= hw_req; // see R16
         end
         // A trap stays pending until the arbiter picks it
         trap_pending_r <= trap_req && !(take && pick == RICTL_SRC_TRAP); // see R15
         // Vector and source hold until the next take or reset
         if (take) begin
            vector_addr <= pick_vec;
            vector_src <= pick;
            if (pick == RICTL_SRC_WIRED) begin
               early_mask_r <= 4'h4; // see R18
            end
         end
      end
   end

endmodule : rictl_core

// *** rictl_core_assertions.sv ***
/*
 Checker on the controller ports, bound at the foot.
 Assumes one clock and sys_rst as a synchronous reset.
*/
`timescale 1ns/1ps
module rictl_core_assertions
   import rictl_pkg::*;
#(
   parameter bit WATCHDOG_RESET_EN = 1'b1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic opcode_fetch,
   input wire logic [15:0] fetch_addr,
   input wire logic watchdog_timeout,
   input wire logic instr_end,
   input wire logic stack_push_done,
   input wire logic stack_pop_done,
   input wire logic device_reset,
   input wire logic mask_bit,
   input wire logic irq_take,
   input wire logic stack_push_req,
   input wire logic stack_pop_req,
   input wire logic resume,
   input wire logic [15:0] vector_addr,
   input wire rictl_src_t vector_src
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ************************************************************
   // Helpers
   // ************************************************************
   // Legal fetch window and the vector each source must show
   wire logic fetch_ok = (fetch_addr >= RAM_LO && fetch_addr <= RAM_HI) ||
      (fetch_addr >= NVM_LO && fetch_addr <= NVM_HI) ||
      (fetch_addr >= VEC_LO && fetch_addr <= VEC_HI);
   wire logic [15:0] src_vec = vector_src == RICTL_SRC_TRAP ? VEC_TRAP :
      vector_src == RICTL_SRC_CAN ? VEC_CAN : vector_src == RICTL_SRC_CTIMER ? VEC_CTIMER :
      vector_src == RICTL_SRC_WIRED ? VEC_WIRED : VEC_WTIMER;
   sequence push_ack;
      stack_push_req && stack_push_done;
   endsequence
   sequence pop_ack;
      stack_pop_req && stack_pop_done;
   endsequence
   // Reset, vectoring and stacking
   chk_reset_vector_mask: assert property (
      device_reset && $past(device_reset) |-> mask_bit && vector_addr == VEC_RESET)
      else $error("reset vector or mask wrong");
   chk_illegal_fetch_reset: assert property (
      opcode_fetch && !fetch_ok && !device_reset |-> ##[0:2] device_reset)
      else $error("illegal fetch gave no reset");
   chk_watchdog_reset: assert property (
      WATCHDOG_RESET_EN && watchdog_timeout && !device_reset |-> ##[0:2] device_reset)
      else $error("watchdog gave no reset");
   chk_take_at_boundary: assert property (
      irq_take |-> instr_end)
      else $error("take away from instruction end");
   chk_masked_trap_only: assert property (
      irq_take && mask_bit |=> vector_src == RICTL_SRC_TRAP)
      else $error("maskable source taken while masked");
   chk_vector_source_match: assert property (
      irq_take |=> vector_addr == src_vec && stack_push_req)
      else $error("vector or push wrong after take");
   chk_mask_after_push: assert property (
      push_ack |=> mask_bit)
      else $error("mask not set after push");
   chk_pop_then_resume: assert property (
      pop_ack |-> ##[1:2] resume)
      else $error("no resume after pop");
endmodule : rictl_core_assertions

bind rictl_core rictl_core_assertions #(.WATCHDOG_RESET_EN(WATCHDOG_RESET_EN))
   rictl_core_assertions_i (.clk, .sys_rst, .opcode_fetch, .fetch_addr, .watchdog_timeout,
   .instr_end, .stack_push_done, .stack_pop_done, .device_reset, .mask_bit, .irq_take,
   .stack_push_req, .stack_pop_req, .resume, .vector_addr, .vector_src);

// *** rictl_cpu_model.sv ***
/*
 CPU core model: acknowledges stack pushes and pops.
 Assumes requests stay high until acked; delay comes from the bench.
*/
`timescale 1ns/1ps
module rictl_cpu_model
   import rictl_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [3:0] ack_delay,
   input wire logic stack_push_req,
   input wire logic stack_pop_req,
   output logic stack_push_done,
   output logic stack_pop_done
);
   logic [3:0] wait_r;
   // ************************************************************
   // Stack timing
   // ************************************************************
   // Counts cycles of an open request
   always_ff @(posedge clk) begin
      if (sys_rst || !(stack_push_req || stack_pop_req)) begin
         wait_r <= 4'h0;
      end else if (wait_r != ack_delay) begin
         wait_r <= wait_r + 4'h1;
      end
   end
   // Push and pop are acknowledged once the delay has run
   assign stack_push_done = stack_push_req && wait_r == ack_delay;
   assign stack_pop_done = stack_pop_req && wait_r == ack_delay;
endmodule : rictl_cpu_model

// *** rictl_core_tb_top.sv ***
/*
 Self-checking bench for the reset and interrupt controller.
 Assumes the CPU model answers stack actions; clock 125 MHz.
*/
`timescale 1ns/1ps
module rictl_core_tb_top
   import rictl_pkg::*;
;
   logic clk = 1'b0, sys_rst = 1'b1, power_on_detect = 1'b0, osc_active = 1'b0;
   logic reset_pin_n = 1'b0, watchdog_timeout = 1'b0, opcode_fetch = 1'b0;
   logic instr_end = 1'b0, instr_is_trap = 1'b0, trap_fetch = 1'b0;
   logic return_from_interrupt = 1'b0, mask_clear_req = 1'b0, mask_set_req = 1'b0;
   logic can_flags_clear = 1'b0, wired_or_pin_interrupt = 1'b0;
   logic wired_flag_write = 1'b0, wired_flag_wdata = 1'b0;
   logic [15:0] fetch_addr = 16'h0000;
   logic [4:0] can_bits = 5'h00;
   logic [3:0] can_irq_enable = 4'h0, ack_delay = 4'h0;
   logic [1:0] ct_flag = 2'h0, ct_en = 2'h0;
   logic [2:0] wt_flag = 3'h0, wide_timer_irq_en = 3'h0;
   logic stack_push_done, stack_pop_done, device_reset, reset_keeps_mode, mask_bit;
   logic irq_take, stack_push_req, stack_pop_req, resume, wired_or_pin_flag;
   logic [15:0] vector_addr;
   rictl_src_t vector_src;
   logic [4:0] can_irq_source_register;
   logic [15:0] vecs [4] = '{VEC_CAN, VEC_WIRED, VEC_CTIMER, VEC_WTIMER};
   logic [15:0] addrs [11] = '{16'h0050, 16'h00FF, 16'h0F00, 16'h1F00, 16'h1FF0,
      16'h1FFF, 16'h004F, 16'h0100, 16'h0EFF, 16'h1F01, 16'h1FEF};
   int mismatches = 0, checks_done = 0;
   // Clock of 8 ns
   always #4 clk = ~clk;
   rictl_core #(.POWER_ON_DELAY(8)) rictl_core_i (.clk, .sys_rst, .power_on_detect,
      .osc_active, .reset_pin_n, .watchdog_timeout, .opcode_fetch, .fetch_addr, .instr_end,
      .instr_is_trap, .trap_fetch, .stack_push_done, .return_from_interrupt, .stack_pop_done,
      .mask_clear_req, .mask_set_req, .can_irq_rx(can_bits[0]), .can_irq_tx(can_bits[1]),
      .can_irq_err(can_bits[2]), .can_irq_ovr(can_bits[3]), .can_irq_wake(can_bits[4]),
      .can_irq_enable, .can_flags_clear, .core_timer_overflow_flag(ct_flag[0]),
      .periodic_tick_flag(ct_flag[1]), .core_timer_overflow_en(ct_en[0]),
      .periodic_tick_en(ct_en[1]), .input_capture_flag(wt_flag[0]),
      .output_compare_flag(wt_flag[1]), .wide_timer_overflow_flag(wt_flag[2]),
      .wide_timer_irq_en, .wired_or_pin_interrupt, .wired_flag_write, .wired_flag_wdata,
      .device_reset, .reset_keeps_mode, .mask_bit, .irq_take, .stack_push_req,
      .stack_pop_req, .resume, .vector_addr, .vector_src, .can_irq_source_register,
      .wired_or_pin_flag);
   rictl_cpu_model rictl_cpu_model_i (.clk, .sys_rst, .ack_delay, .stack_push_req,
      .stack_pop_req, .stack_push_done, .stack_pop_done);
   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic step;
      @(posedge clk);
   endtask : step
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done;
      if (mismatches == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : test_done
   // Bounded wait: mask set, resume, reset released or wired flag
   task automatic wait_for(input int sel);
      for (int n = 0; n < 60; n++) begin
         step;
         #1;
         if ((sel == 0 ? mask_bit : sel == 1 ? resume : sel == 2 ? !device_reset :
            wired_or_pin_flag) === 1'b1) return;
      end
      check(16'h0000, 16'h0001);
      test_done;
   endtask : wait_for
   // Ends one instruction; a nonzero vec expects a take, stacking and return
   task automatic take(input logic trap, input logic [15:0] vec);
      trap_fetch <= trap;
      step;
      trap_fetch <= 1'b0;
      instr_end <= 1'b1;
      instr_is_trap <= trap;
      #1;
      check(irq_take, vec != 16'h0000);
      step;
      instr_end <= 1'b0;
      instr_is_trap <= 1'b0;
      if (vec != 16'h0000) begin
         #1;
         check(vector_addr, vec);
         wait_for(0);
         return_from_interrupt <= 1'b1;
         step;
         return_from_interrupt <= 1'b0;
         wait_for(1);
      end
   endtask : take
   task automatic mask(input logic set);
      step;
      mask_set_req <= set;
      mask_clear_req <= !set;
      step;
      mask_set_req <= 1'b0;
      mask_clear_req <= 1'b0;
   endtask : mask
   // Drops one source and clears its flag
   task automatic clear_src(input int i);
      step;
      case (i)
         0: can_bits <= 5'h00;
         1: wired_or_pin_interrupt <= 1'b0;
         2: ct_flag <= 2'h0;
         default: wt_flag <= 3'h0;
      endcase
      can_flags_clear <= i == 0;
      wired_flag_write <= i == 1;
      step;
      can_flags_clear <= 1'b0;
      wired_flag_write <= 1'b0;
   endtask : clear_src
   // Fetch, watchdog or pin low for len cycles; watch 8 cycles for reset
   task automatic fire(input int sel, input logic [15:0] addr, input int len, input logic exp);
      logic seen;
      seen = 1'b0;
      step;
      opcode_fetch <= sel == 0;
      fetch_addr <= addr;
      watchdog_timeout <= sel == 1;
      reset_pin_n <= sel != 2;
      for (int n = 0; n < 8; n++) begin
         #1;
         seen |= device_reset;
         step;
         if (n == len - 1) begin
            opcode_fetch <= 1'b0;
            watchdog_timeout <= 1'b0;
            reset_pin_n <= 1'b1;
         end
      end
      check(seen, exp);
      if (seen) wait_for(2);
   endtask : fire
   // Main sequence
   initial begin
      repeat (16) step;
      sys_rst <= 1'b0;
      power_on_detect <= 1'b1;
      osc_active <= 1'b1;
      step;
      power_on_detect <= 1'b0;
      repeat (30) step;
      check(device_reset, 1'b1);
      reset_pin_n <= 1'b1;
      wait_for(2);
      check(mask_bit, 1'b1);
      check(vector_addr, VEC_RESET);
      mask(1'b0);
      ct_flag <= 2'h3;
      take(1'b0, 16'h0000);
      can_bits <= 5'h10;
      mask(1'b1);
      take(1'b0, 16'h0000);
      check(can_irq_source_register, 5'h10);
      take(1'b1, VEC_TRAP);
      can_bits <= 5'h1F;
      can_irq_enable <= 4'hF;
      ct_en <= 2'h3;
      wt_flag <= 3'h7;
      wide_timer_irq_en <= 3'h7;
      wired_or_pin_interrupt <= 1'b1;
      wait_for(3);
      check(can_irq_source_register, 5'h1F);
      ack_delay <= 4'h3;
      for (int i = 0; i < 4; i++) begin
         mask(1'b0);
         take(1'b0, vecs[i]);
         check(wired_or_pin_flag, i < 2);
         clear_src(i);
      end
      mask(1'b0);
      take(1'b0, 16'h0000);
      foreach (addrs[k]) fire(0, addrs[k], 1, k > 5);
      fire(1, 16'h0000, 1, 1'b1);
      check(reset_keeps_mode, 1'b1);
      fire(2, 16'h0000, 1, 1'b0);
      fire(2, 16'h0000, 2, 1'b1);
      check(reset_keeps_mode, 1'b0);
      test_done;
   end
endmodule : rictl_core_tb_top
